// *** include/hrbpc_pkg.sv ***
// Constants, types and register map of the hub reset, boot and port control block
package hrbpc_pkg;

  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_PORT = 8'h04;
  localparam logic [7:0] A_LPM = 8'h08;
  localparam logic [7:0] A_STAT = 8'h0C;
  localparam logic [7:0] A_OTP = 8'h10;
  localparam logic [7:0] A_USB = 8'h14;
  // SMBus-only terminating register
  localparam logic [7:0] A_CFG_END = 8'hFF;

  // ==========================================================
  // Field positions
  localparam int NPORT = 4;
  localparam int CTRL_GANG = 0;
  localparam int CTRL_SWPWR = 1;
  localparam int CTRL_BC = 4;
  localparam int STAT_BOOT_EXT = 0;
  localparam int STAT_BOOT_DONE = 1;
  localparam int STAT_SMB_EN = 2;
  localparam int STAT_CFG_WAIT = 3;
  localparam int STAT_OC = 8;
  localparam int LPM_CUR = 0;
  localparam int LPM_TGT = 2;
  localparam int LPM_BUSY = 4;
  localparam int OTP_DATA = 0;
  localparam int OTP_ADDR = 8;
  localparam int OTP_MODE = 24;
  localparam int USB_ADDR = 0;
  localparam int USB_CFGD = 7;

  // ==========================================================
  // Reset values
  localparam logic [NPORT-1:0] PORT_RST = 4'h0;
  localparam logic [6:0] USB_ADDR_RST = 7'h00;
  localparam logic [9:0] SYNC_RST = 10'h3FF;
  localparam logic PIN_LOW = 1'b0;

  // ==========================================================
  // Boot signature
  localparam logic [15:0] SIG_ADDR = 16'hFFFA;
  localparam logic [31:0] SIG_WORD = 32'h32444655;
  localparam logic [15:0] BOOT_VEC = 16'h0000;
  localparam logic [1:0] SIG_LAST = 2'h3;

  // ==========================================================
  // Timing
  localparam int unsigned CLK_MHZ = 40;
  localparam int unsigned POR_HOLD_US = 100;
  localparam int unsigned L1_ENTRY_US = 10;
  localparam int unsigned L1_EXIT_US = 50;
  localparam int unsigned L2_ENTRY_US = 3000;
  localparam int unsigned L2_EXIT_US = 2000;
  localparam int POR_W = 12;
  localparam int TMR_W = 17;
  localparam int OC_W = 3;
  localparam logic [POR_W-1:0] POR_CYC = POR_W'(POR_HOLD_US * CLK_MHZ);
  // One cycle short of the limit, so sleep latencies stay strictly under it
  localparam logic [TMR_W-1:0] L1_ENTRY_CYC = TMR_W'(L1_ENTRY_US * CLK_MHZ - 1);
  localparam logic [TMR_W-1:0] L1_EXIT_CYC = TMR_W'(L1_EXIT_US * CLK_MHZ - 1);
  // Eight consecutive low samples make an over-current
  localparam logic [OC_W-1:0] OC_LAST = 3'h7;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {LINK_ON, LINK_SLEEP, LINK_SUSPEND} hrbpc_link_t;
  typedef enum logic [1:0] {OTP_SINGLE, OTP_DIFF, OTP_REDUND, OTP_DIFF_REDUND} hrbpc_otp_mode_t;
  typedef enum logic [1:0] {BT_STRAP, BT_READ, BT_EXT, BT_INT} hrbpc_boot_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
    logic [31:0] wdata;
  } hrbpc_smb_req_t;

  typedef struct packed {
    logic go;
    hrbpc_otp_mode_t mode;
    logic [12:0] addr;
    logic [7:0] data;
  } hrbpc_otp_cmd_t;

endpackage

// *** logic/hrbpc_top.sv ***
// Hub reset, boot source, SMBus access, link power and port power control
// Contract
// - Serial-flash strap: after reset read flash signature "2DFU" from 0xFFFA.
// - Signature match: flash becomes code memory, fetch starts at address 0x0000.
// - Missing or wrong signature: flash ignored, execution stays on internal ROM.
// - SMBus slave enabled only if both SMBus lines show pull-ups.
// - SMBus host reads and writes run-time registers and programs OTP.
// - SMBus OTP programming offers single, differential, redundant, differential-redundant modes.
// - OTP access from the USB host side uses single-ended mode only.
// - Battery-charging indication is set independently for each downstream port.
// - Three reset sources: power-on, chip reset pin, upstream USB bus reset.
// - Power-on starts a timer holding internal reset for a fixed interval.
// - Chip reset: PHY high-impedance, transfers aborted, defaults restored, oscillator and PLL stopped.
// - USB bus reset: address zero, unconfigured, leave suspend.
// - USB bus reset is never passed to downstream ports.
// - Three link states: on, sleep, suspend.
// - Sleep entry under 10 us, sleep exit under 50 us.
// - Suspend entry about 3 ms, suspend exit about 2 ms.
// - One two-way pin per port for power enable and over-current sense.
// - Ganged mode: one shared pin controls power and senses over-current.
// - Power off drives pin low, pull-up off; power on releases, pull-up on.
// - Low on the pin while powered means over-current on that port.
//
// The implementer's own choices: the APB slave port and the register offsets.
module hrbpc_top #(
  parameter int unsigned L2_ENTRY_CYC = hrbpc_pkg::L2_ENTRY_US * hrbpc_pkg::CLK_MHZ,
  parameter int unsigned L2_EXIT_CYC = hrbpc_pkg::L2_EXIT_US * hrbpc_pkg::CLK_MHZ
) (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Reset pins and reset effects
  input wire logic por_n_pin,
  input wire logic chip_rst_n_pin,
  output logic core_rst,
  output logic phy_hiz,
  output logic osc_pll_run,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Boot strap and serial flash reader
  input wire logic flash_boot_strap,
  output logic flash_rd_req,
  output logic [15:0] flash_addr,
  input wire logic flash_ack,
  input wire logic [7:0] flash_byte,
  output logic flash_code_en,
  output logic boot_done,
  // SMBus slave
  input wire logic smbus_data_line,
  input wire logic smbus_clock_line,
  input wire hrbpc_pkg::hrbpc_smb_req_t smb_req,
  output logic smb_ack,
  output logic [31:0] smb_rdata,
  output logic smbus_en,
  output logic cfg_wait,
  // OTP programmer
  output hrbpc_pkg::hrbpc_otp_cmd_t otp_cmd,
  // Upstream USB
  input wire logic usb_bus_reset,
  output logic [6:0] usb_addr,
  output logic usb_configured,
  output hrbpc_pkg::hrbpc_link_t link_state,
  // Downstream ports
  input wire logic [3:0] hub_port_pwr,
  input wire logic [3:0] port_power_sense_pins_i,
  output logic [3:0] port_power_sense_pins_o,
  output logic [3:0] port_power_sense_pins_oe,
  output logic [3:0] port_pullup_en,
  input wire logic shared_power_sense_pin_i,
  output logic shared_power_sense_pin_o,
  output logic shared_power_sense_pin_oe,
  output logic shared_pullup_en,
  output logic [3:0] over_current_flag,
  output logic [3:0] bc_port_ind
);

  // ==========================================================
  // Pin synchronisers
  logic [9:0] sync1_ff;
  logic [9:0] sync2_ff;
  wire logic [9:0] pin_raw = {smbus_clock_line, smbus_data_line, flash_boot_strap, chip_rst_n_pin,
                              por_n_pin, shared_power_sense_pin_i, port_power_sense_pins_i};

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sync1_ff <= hrbpc_pkg::SYNC_RST;
      sync2_ff <= hrbpc_pkg::SYNC_RST;
    end else if (ce) begin
      sync1_ff <= pin_raw;
      sync2_ff <= sync1_ff;
    end
  end

  wire logic [3:0] port_s = sync2_ff[3:0];
  wire logic shared_s = sync2_ff[4];
  wire logic por_s = sync2_ff[5];
  wire logic chip_rst_s = !sync2_ff[6];
  wire logic strap_s = sync2_ff[7];
  wire logic smb_pullups = sync2_ff[8] && sync2_ff[9];

  // ==========================================================
  // Reset sources
  logic [hrbpc_pkg::POR_W-1:0] por_cnt_ff;
  logic core_rst_ff;
  logic phy_hiz_ff;
  logic osc_run_ff;
  wire logic por_busy = !por_s || (por_cnt_ff != '0);
  // Internal reset joins every source except the USB bus reset
  wire logic rst_int = !rst_n || por_busy || chip_rst_s;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      por_cnt_ff <= hrbpc_pkg::POR_CYC;
    end else if (ce) begin
      if (!por_s) begin
        por_cnt_ff <= hrbpc_pkg::POR_CYC;
      end else if (por_cnt_ff != '0) begin
        por_cnt_ff <= por_cnt_ff - 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      core_rst_ff <= 1'b1;
      phy_hiz_ff <= 1'b1;
      osc_run_ff <= 1'b0;
    end else if (ce) begin
      core_rst_ff <= rst_int;
      phy_hiz_ff <= rst_int;
      osc_run_ff <= !chip_rst_s;
    end
  end

  // ==========================================================
  // State declarations
  hrbpc_pkg::hrbpc_boot_t boot_ff;
  hrbpc_pkg::hrbpc_boot_t nxt_boot;
  logic [31:0] sig_ff;
  logic [1:0] sig_idx_ff;
  logic [15:0] faddr_ff;
  logic smb_init_ff;
  logic smb_en_ff;
  logic cfg_wait_ff;
  logic [31:0] smb_rdata_ff;
  logic [31:0] prdata_ff;
  logic gang_ff;
  logic swpwr_ff;
  logic [3:0] bc_ff;
  logic [3:0] port_ff;
  hrbpc_pkg::hrbpc_otp_cmd_t otp_ff;
  logic otp_smb_ff;
  logic [6:0] usb_addr_ff;
  logic cfgd_ff;
  hrbpc_pkg::hrbpc_link_t link_ff;
  hrbpc_pkg::hrbpc_link_t tgt_ff;
  hrbpc_pkg::hrbpc_link_t req_st;
  logic [hrbpc_pkg::TMR_W-1:0] tmr_ff;
  logic [hrbpc_pkg::OC_W-1:0] oc_cnt_ff [4];
  logic [3:0] oc_ff;
  wire logic lpm_busy = link_ff != tgt_ff;

  function automatic logic [31:0] reg_read(input logic [7:0] a);
    logic [31:0] r;
    r = '0;
    case (a)
      hrbpc_pkg::A_CTRL: begin
        r[hrbpc_pkg::CTRL_GANG] = gang_ff;
        r[hrbpc_pkg::CTRL_SWPWR] = swpwr_ff;
        r[hrbpc_pkg::CTRL_BC +: 4] = bc_ff;
      end
      hrbpc_pkg::A_PORT: r[3:0] = port_ff;
      hrbpc_pkg::A_LPM: begin
        r[hrbpc_pkg::LPM_CUR +: 2] = link_ff;
        r[hrbpc_pkg::LPM_TGT +: 2] = tgt_ff;
        r[hrbpc_pkg::LPM_BUSY] = lpm_busy;
      end
      hrbpc_pkg::A_STAT: begin
        r[hrbpc_pkg::STAT_BOOT_EXT] = boot_ff == hrbpc_pkg::BT_EXT;
        r[hrbpc_pkg::STAT_BOOT_DONE] = boot_ff == hrbpc_pkg::BT_EXT || boot_ff == hrbpc_pkg::BT_INT;
        r[hrbpc_pkg::STAT_SMB_EN] = smb_en_ff;
        r[hrbpc_pkg::STAT_CFG_WAIT] = cfg_wait_ff;
        r[hrbpc_pkg::STAT_OC +: 4] = oc_ff;
      end
      hrbpc_pkg::A_OTP: begin
        r[hrbpc_pkg::OTP_DATA +: 8] = otp_ff.data;
        r[hrbpc_pkg::OTP_ADDR +: 13] = otp_ff.addr;
        r[hrbpc_pkg::OTP_MODE +: 2] = otp_ff.mode;
      end
      hrbpc_pkg::A_USB: begin
        r[hrbpc_pkg::USB_ADDR +: 7] = usb_addr_ff;
        r[hrbpc_pkg::USB_CFGD] = cfgd_ff;
      end
      default: r = '0;
    endcase
    return r;
  endfunction

  // ==========================================================
  // Boot source selection
  wire logic [31:0] nxt_sig = {sig_ff[23:0], flash_byte};
  wire logic sig_last = flash_ack && (sig_idx_ff == hrbpc_pkg::SIG_LAST);
  wire logic sig_ok = nxt_sig == hrbpc_pkg::SIG_WORD;

  always_comb begin
    nxt_boot = boot_ff;
    case (boot_ff)
      hrbpc_pkg::BT_STRAP: nxt_boot = strap_s ? hrbpc_pkg::BT_READ : hrbpc_pkg::BT_INT;
      hrbpc_pkg::BT_READ: begin
        if (sig_last) begin
          nxt_boot = sig_ok ? hrbpc_pkg::BT_EXT : hrbpc_pkg::BT_INT;
        end
      end
      hrbpc_pkg::BT_EXT: nxt_boot = hrbpc_pkg::BT_EXT;
      hrbpc_pkg::BT_INT: nxt_boot = hrbpc_pkg::BT_INT;
      default: nxt_boot = hrbpc_pkg::BT_STRAP;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst_int) begin
      boot_ff <= hrbpc_pkg::BT_STRAP;
      sig_ff <= '0;
      sig_idx_ff <= '0;
      faddr_ff <= hrbpc_pkg::SIG_ADDR;
    end else if (ce) begin
      boot_ff <= nxt_boot;
      if (boot_ff == hrbpc_pkg::BT_READ && flash_ack) begin
        sig_ff <= nxt_sig;
        sig_idx_ff <= sig_idx_ff + 1'b1;
        faddr_ff <= sig_last ? hrbpc_pkg::BOOT_VEC : faddr_ff + 1'b1;
      end
    end
  end

  // ==========================================================
  // Register access: APB first, SMBus fills cycles with no APB access phase
  wire logic apb_acc = psel && penable;
  wire logic apb_hit = paddr == hrbpc_pkg::A_CTRL || paddr == hrbpc_pkg::A_PORT || paddr == hrbpc_pkg::A_LPM ||
                       paddr == hrbpc_pkg::A_STAT || paddr == hrbpc_pkg::A_OTP || paddr == hrbpc_pkg::A_USB;
  wire logic apb_wr = apb_acc && pwrite && apb_hit;
  wire logic smb_go = smb_req.valid && smb_en_ff && !apb_acc && !rst_int;
  wire logic smb_wr = smb_go && smb_req.write;
  wire logic wr_en = apb_wr || smb_wr;
  wire logic [7:0] wr_addr = apb_wr ? paddr : smb_req.addr;
  wire logic [31:0] wr_data = apb_wr ? pwdata : smb_req.wdata;
  wire logic wr_ctrl = wr_en && wr_addr == hrbpc_pkg::A_CTRL;
  wire logic wr_port = wr_en && wr_addr == hrbpc_pkg::A_PORT;
  wire logic wr_otp = wr_en && wr_addr == hrbpc_pkg::A_OTP;
  wire logic wr_usb = wr_en && wr_addr == hrbpc_pkg::A_USB;
  wire logic [3:0] oc_clr = (wr_en && wr_addr == hrbpc_pkg::A_STAT) ? wr_data[hrbpc_pkg::STAT_OC +: 4] : '0;
  wire logic cfg_end = smb_wr && smb_req.addr == hrbpc_pkg::A_CFG_END;

  always_ff @(posedge clk) begin
    if (rst_int) begin
      prdata_ff <= '0;
      smb_rdata_ff <= '0;
    end else if (ce) begin
      if (psel && !penable) begin
        prdata_ff <= reg_read(paddr);
      end
      if (smb_go) begin
        smb_rdata_ff <= reg_read(smb_req.addr);
      end
    end
  end

  // Pull-ups are sampled once, after every reset source except the USB bus reset has released
  always_ff @(posedge clk) begin
    if (rst_int) begin
      smb_init_ff <= 1'b0;
      smb_en_ff <= 1'b0;
      cfg_wait_ff <= 1'b0;
    end else if (ce) begin
      if (!smb_init_ff) begin
        smb_init_ff <= 1'b1;
        smb_en_ff <= smb_pullups;
        cfg_wait_ff <= smb_pullups;
      end else if (cfg_end) begin
        cfg_wait_ff <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Control registers, OTP command, USB device state
  always_ff @(posedge clk) begin
    if (rst_int) begin
      gang_ff <= 1'b0;
      swpwr_ff <= 1'b0;
      bc_ff <= hrbpc_pkg::PORT_RST;
      port_ff <= hrbpc_pkg::PORT_RST;
      otp_ff <= '0;
      otp_smb_ff <= 1'b0;
    end else if (ce) begin
      if (wr_ctrl) begin
        gang_ff <= wr_data[hrbpc_pkg::CTRL_GANG];
        swpwr_ff <= wr_data[hrbpc_pkg::CTRL_SWPWR];
        bc_ff <= wr_data[hrbpc_pkg::CTRL_BC +: 4];
      end
      if (wr_port) begin
        port_ff <= wr_data[3:0];
      end
      otp_ff.go <= wr_otp;
      if (wr_otp) begin
        otp_smb_ff <= !apb_wr;
        otp_ff.data <= wr_data[hrbpc_pkg::OTP_DATA +: 8];
        otp_ff.addr <= wr_data[hrbpc_pkg::OTP_ADDR +: 13];
        // USB-side software path is held to single-ended storage
        otp_ff.mode <= apb_wr ? hrbpc_pkg::OTP_SINGLE :
                       hrbpc_pkg::hrbpc_otp_mode_t'(wr_data[hrbpc_pkg::OTP_MODE +: 2]);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst_int) begin
      usb_addr_ff <= hrbpc_pkg::USB_ADDR_RST;
      cfgd_ff <= 1'b0;
    end else if (ce) begin
      if (usb_bus_reset) begin
        usb_addr_ff <= hrbpc_pkg::USB_ADDR_RST;
        cfgd_ff <= 1'b0;
      end else if (wr_usb) begin
        usb_addr_ff <= wr_data[hrbpc_pkg::USB_ADDR +: 7];
        cfgd_ff <= wr_data[hrbpc_pkg::USB_CFGD];
      end
    end
  end

  // ==========================================================
  // Link power states; sleep and suspend only go via on
  assign req_st = hrbpc_pkg::hrbpc_link_t'(wr_data[hrbpc_pkg::LPM_CUR +: 2]);
  wire logic req_low = req_st == hrbpc_pkg::LINK_SLEEP || req_st == hrbpc_pkg::LINK_SUSPEND;
  wire logic lpm_legal = (link_ff == hrbpc_pkg::LINK_ON) ? req_low : (req_st == hrbpc_pkg::LINK_ON);
  wire logic lpm_go = wr_en && wr_addr == hrbpc_pkg::A_LPM && !lpm_busy && lpm_legal;
  wire logic [hrbpc_pkg::TMR_W-1:0] l2_in = hrbpc_pkg::TMR_W'(L2_ENTRY_CYC);
  wire logic [hrbpc_pkg::TMR_W-1:0] l2_out = hrbpc_pkg::TMR_W'(L2_EXIT_CYC);
  wire logic [hrbpc_pkg::TMR_W-1:0] nxt_lat =
    (req_st == hrbpc_pkg::LINK_SLEEP) ? hrbpc_pkg::L1_ENTRY_CYC :
    (req_st == hrbpc_pkg::LINK_SUSPEND) ? l2_in :
    (link_ff == hrbpc_pkg::LINK_SLEEP) ? hrbpc_pkg::L1_EXIT_CYC : l2_out;

  always_ff @(posedge clk) begin
    if (rst_int) begin
      link_ff <= hrbpc_pkg::LINK_ON;
      tgt_ff <= hrbpc_pkg::LINK_ON;
      tmr_ff <= '0;
    end else if (ce) begin
      if (usb_bus_reset) begin
        link_ff <= hrbpc_pkg::LINK_ON;
        tgt_ff <= hrbpc_pkg::LINK_ON;
        tmr_ff <= '0;
      end else if (lpm_go) begin
        tgt_ff <= req_st;
        tmr_ff <= nxt_lat;
      end else if (lpm_busy) begin
        tmr_ff <= tmr_ff - 1'b1;
        if (tmr_ff <= 1) begin
          link_ff <= tgt_ff;
          tmr_ff <= '0;
        end
      end
    end
  end

  // ==========================================================
  // Port power and over-current; bus reset never touches these
  // Ports stay off while any reset holds the core, whatever the hub asks
  wire logic [3:0] pwr_src = rst_int ? hrbpc_pkg::PORT_RST : (swpwr_ff ? port_ff : hub_port_pwr);
  wire logic [3:0] pwr_eff = gang_ff ? {4{pwr_src[0]}} : pwr_src;
  wire logic [3:0] sense = gang_ff ? {4{shared_s}} : port_s;
  logic [3:0] oc_hit;

  always_comb begin
    for (int i = 0; i < hrbpc_pkg::NPORT; i++) begin
      oc_hit[i] = pwr_eff[i] && !sense[i] && (oc_cnt_ff[i] == hrbpc_pkg::OC_LAST);
    end
  end

  // Filter rides out the dip while the switch charges the load
  always_ff @(posedge clk) begin
    if (rst_int) begin
      for (int i = 0; i < hrbpc_pkg::NPORT; i++) begin
        oc_cnt_ff[i] <= '0;
      end
      oc_ff <= '0;
    end else if (ce) begin
      for (int i = 0; i < hrbpc_pkg::NPORT; i++) begin
        if (!pwr_eff[i] || sense[i]) begin
          oc_cnt_ff[i] <= '0;
        end else if (oc_cnt_ff[i] != hrbpc_pkg::OC_LAST) begin
          oc_cnt_ff[i] <= oc_cnt_ff[i] + 1'b1;
        end
      end
      // A new fault outranks a clear in the same cycle
      oc_ff <= oc_hit | (oc_ff & ~oc_clr);
    end
  end

  // ==========================================================
  // Outputs
  assign port_power_sense_pins_o = {4{hrbpc_pkg::PIN_LOW}};
  assign port_power_sense_pins_oe = gang_ff ? 4'h0 : ~pwr_eff;
  assign port_pullup_en = gang_ff ? 4'h0 : pwr_eff;
  assign shared_power_sense_pin_o = hrbpc_pkg::PIN_LOW;
  assign shared_power_sense_pin_oe = gang_ff && !pwr_eff[0];
  assign shared_pullup_en = gang_ff && pwr_eff[0];
  assign over_current_flag = oc_ff;
  assign bc_port_ind = bc_ff;
  assign core_rst = core_rst_ff;
  assign phy_hiz = phy_hiz_ff;
  assign osc_pll_run = osc_run_ff;
  assign prdata = prdata_ff;
  assign pready = apb_acc;
  assign pslverr = apb_acc && !apb_hit;
  assign flash_rd_req = boot_ff == hrbpc_pkg::BT_READ;
  assign flash_addr = faddr_ff;
  assign flash_code_en = boot_ff == hrbpc_pkg::BT_EXT;
  assign boot_done = boot_ff == hrbpc_pkg::BT_EXT || boot_ff == hrbpc_pkg::BT_INT;
  assign smb_ack = smb_go;
  assign smb_rdata = smb_rdata_ff;
  assign smbus_en = smb_en_ff;
  assign cfg_wait = cfg_wait_ff;
  assign otp_cmd = otp_ff;
  assign usb_addr = usb_addr_ff;
  assign usb_configured = cfgd_ff;
  assign link_state = link_ff;

  // ==========================================================
  // Checks
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n || !ce || rst_int);

  sequence strap_seen;
    boot_ff == hrbpc_pkg::BT_STRAP && strap_s;
  endsequence
  sequence sig_done;
    boot_ff == hrbpc_pkg::BT_READ && sig_last;
  endsequence
  sequence oc_low;
    (pwr_eff[0] && !sense[0])[*8];
  endsequence
  sequence sleep_go;
    lpm_go && req_st == hrbpc_pkg::LINK_SLEEP;
  endsequence

  sig_read_a: assert property (strap_seen |=> flash_rd_req && flash_addr == hrbpc_pkg::SIG_ADDR)
    else $error("signature read did not start at its address");
  ext_boot_a: assert property (sig_done ##0 sig_ok |=> flash_code_en && flash_addr == hrbpc_pkg::BOOT_VEC)
    else $error("matching signature did not enable flash code at zero");
  int_boot_a: assert property ((sig_done ##0 !sig_ok) or (boot_ff == hrbpc_pkg::BT_STRAP && !strap_s)
    |=> (boot_done && !flash_code_en) [*4])
    else $error("flash used without valid signature");
  smb_gate_a: assert property (smb_ack |-> smbus_en && !(psel && penable))
    else $error("SMBus served without pull-ups or over APB");
  otp_usb_a: assert property ($rose(otp_cmd.go) && !otp_smb_ff |-> otp_cmd.mode == hrbpc_pkg::OTP_SINGLE)
    else $error("USB side OTP not single-ended");
  chip_rst_a: assert property (@(posedge clk) disable iff (!rst_n || !ce) chip_rst_s |-> port_pullup_en == 4'h0
    ##1 phy_hiz && !osc_pll_run && usb_addr == hrbpc_pkg::USB_ADDR_RST)
    else $error("chip reset did not quiet the device");
  bus_rst_a: assert property (usb_bus_reset |=> usb_addr == hrbpc_pkg::USB_ADDR_RST && !usb_configured
    && link_state == hrbpc_pkg::LINK_ON)
    else $error("bus reset left address, configuration or suspend");
  sleep_time_a: assert property (sleep_go |-> ##[399:399] link_state == hrbpc_pkg::LINK_ON
    ##1 link_state == hrbpc_pkg::LINK_SLEEP)
    else $error("sleep entry not at its cycle count");
  oc_filter_a: assert property (oc_low |=> over_current_flag[0])
    else $error("sustained low while powered not flagged");
  oc_glitch_a: assert property ($rose(over_current_flag[0]) |-> $past(pwr_eff[0] && !sense[0], 8))
    else $error("over-current flagged without filtered low");
  pin_drive_a: assert property (!gang_ff && !pwr_eff[1] |-> port_power_sense_pins_oe[1] && !port_pullup_en[1]
    && !port_power_sense_pins_o[1])
    else $error("disabled port not driven low");

endmodule

// *** tb/hrbpc_flash_model.sv ***
// Behavioural serial flash that serves the boot signature
module hrbpc_flash_model (
  // Clock
  input wire logic clk,
  // Reader side
  input wire logic req,
  input wire logic [15:0] addr,
  input wire logic bad,
  output logic ack,
  output logic [7:0] data
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [31:0] sig = "2DFU";
  logic [1:0] k;
  // Byte 0 of the signature sits at 0xFFFA
  assign k = addr[1:0] + 2'h2;
  initial ack = 1'b0;
  initial data = 8'h00;
  // One byte every other cycle: a slow device
  always @(posedge clk) begin
    ack <= req & ~ack;
    // Idle bus shows the inverse of its last value
    data <= (req & ~ack) ? sig[8 * (3 - k) +: 8] ^ {7'h00, bad} : ~data;
  end
endmodule

// *** tb/testbench.sv ***
// Self-checking bench for the hub reset, boot and port control block
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e;} hrbpc_row_t;
  logic clk = 0, rst_n = 0, ce = 1, por_n_pin = 1, chip_rst_n_pin = 1, psel = 0, penable = 0, pwrite = 0;
  logic flash_boot_strap = 1, smbus_data_line = 1, smbus_clock_line = 1, usb_bus_reset = 0, bad = 0, err;
  logic core_rst, phy_hiz, osc_pll_run, pready, pslverr, flash_rd_req, flash_code_en, boot_done, smb_ack;
  logic smbus_en, cfg_wait, usb_configured, shared_power_sense_pin_i, shared_power_sense_pin_o;
  logic shared_power_sense_pin_oe, shared_pullup_en, flash_ack;
  logic [3:0] hub_port_pwr = 4'h0, fault = 4'h0, port_power_sense_pins_i, port_power_sense_pins_o;
  logic [3:0] port_power_sense_pins_oe, port_pullup_en, over_current_flag, bc_port_ind;
  logic [6:0] usb_addr;
  logic [7:0] paddr = 8'h00, flash_byte;
  logic [15:0] flash_addr;
  logic [31:0] pwdata = 32'h0, prdata, smb_rdata, r;
  hrbpc_pkg::hrbpc_smb_req_t smb_req = '0;
  hrbpc_pkg::hrbpc_otp_cmd_t otp_cmd;
  hrbpc_pkg::hrbpc_link_t link_state;
  int fails = 0, samples_checked = 0, n;
  int lm[3] = '{402, 2002, 52};
  logic [1:0] tg[3] = '{2'h1, 2'h0, 2'h2};
  hrbpc_row_t rows[5] = '{'{8'h00, 32'hA0, 32'hA0}, '{8'h04, 32'h5, 32'h5}, '{8'h14, 32'h85, 32'h85},
    '{8'h0C, 32'hFFFF_FFFF, 32'hF}, '{8'h40, 32'h1, 32'h0}};
  always #12.5 clk = ~clk;
  // Pull-ups hold released pins high; a fault pulls low
  assign port_power_sense_pins_i = (~port_power_sense_pins_oe | port_power_sense_pins_o) & ~fault;
  assign shared_power_sense_pin_i = ~shared_power_sense_pin_oe | shared_power_sense_pin_o;
  hrbpc_top #(.L2_ENTRY_CYC(50), .L2_EXIT_CYC(30)) hrbpc_top_inst (.*);
  hrbpc_flash_model hrbpc_flash_model_inst (.clk(clk), .req(flash_rd_req), .addr(flash_addr), .bad(bad),
    .ack(flash_ack), .data(flash_byte));
  // ==========================================================
  // Checks and bus cycles
  task chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("BAD %0t %h %h", $time, g, e);
    end
  endtask
  task summarize;
    if (fails == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task to(input logic ok);
    if (ok !== 1'b1) begin
      fails++;
      summarize;
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    for (n = 0; n < 50 && !(pready === 1'b1 && penable === 1'b1); n++) @(posedge clk);
    to(pready === 1'b1);
    r = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task smb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    smb_req <= '{1'b1, w, a, d};
    for (n = 0; n < 50 && !(smb_ack === 1'b1 && smb_req.valid === 1'b1); n++) @(posedge clk);
    to(smb_ack === 1'b1);
    smb_req.valid <= 0;
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1;
    for (n = 0; n < 5000 && boot_done !== 1'b1; n++) @(posedge clk);
    to(boot_done === 1'b1);
    chk(flash_code_en, 1);
    chk(flash_addr, 16'h0000);
    chk(smbus_en, 1);
    foreach (rows[i]) begin
      apb(1, rows[i].a, rows[i].d);
      apb(0, rows[i].a, 32'h0);
      chk(r, rows[i].e);
      chk(err, rows[i].a == 8'h40);
    end
    #1 chk(bc_port_ind, 4'hA);
    apb(1, 8'h10, 32'h0300_1234);
    #1 chk(otp_cmd.mode, 2'h0);
    chk(otp_cmd.go, 1);
    for (int m = 0; m < 4; m++) begin
      smb(1, 8'h10, {6'h00, m[1:0], 24'h001234});
      #1 chk(otp_cmd.mode, m[1:0]);
    end
    smb(0, 8'h14, 32'h0);
    #1 chk(smb_rdata, 32'h85);
    chk(cfg_wait, 1);
    smb(1, 8'hFF, 32'h0);
    #1 chk(cfg_wait, 0);
    apb(1, 8'h00, 32'h2);
    apb(1, 8'h04, 32'h1);
    repeat (3) @(posedge clk);
    chk(port_power_sense_pins_oe, 4'hE);
    chk(port_pullup_en, 4'h1);
    fault <= 4'h3;
    repeat (6) @(posedge clk);
    fault <= 4'h0;
    repeat (12) @(posedge clk);
    chk(over_current_flag, 4'h0);
    fault <= 4'h3;
    repeat (14) @(posedge clk);
    fault <= 4'h0;
    chk(over_current_flag, 4'h1);
    apb(1, 8'h00, 32'h3);
    repeat (3) @(posedge clk);
    chk(shared_power_sense_pin_oe, 0);
    chk(shared_pullup_en, 1);
    chk(port_power_sense_pins_oe, 4'h0);
    foreach (tg[i]) begin
      apb(1, 8'h08, {30'h0, tg[i]});
      for (n = 0; n < lm[i] && link_state !== tg[i]; n++) @(posedge clk);
      chk(link_state, tg[i]);
    end
    usb_bus_reset <= 1;
    @(posedge clk);
    usb_bus_reset <= 0;
    #1 chk(usb_addr, 7'h00);
    chk(usb_configured, 0);
    chk(link_state, 2'h0);
    chk(shared_power_sense_pin_oe, 0);
    chk(shared_pullup_en, 1);
    apb(1, 8'h00, 32'h0);
    hub_port_pwr <= 4'h6;
    #1 chk(port_pullup_en, 4'h6);
    chk(port_power_sense_pins_oe, 4'h9);
    @(posedge clk);
    bad <= 1;
    smbus_data_line <= 0;
    chip_rst_n_pin <= 0;
    repeat (5) @(posedge clk);
    chk(phy_hiz, 1);
    chk(osc_pll_run, 0);
    chk(port_pullup_en, 4'h0);
    chk(core_rst, 1);
    chip_rst_n_pin <= 1;
    for (n = 0; n < 200 && boot_done !== 1'b1; n++) @(posedge clk);
    to(boot_done === 1'b1);
    chk(flash_code_en, 0);
    chk(smbus_en, 0);
    apb(0, 8'h04, 32'h0);
    chk(r, 32'h0);
    summarize;
  end
endmodule
